// [verilog/lfu_defines.svh]
// constants of the logic function unit: bus offsets, field positions,
// reset values and configuration encodings.
// assumes nothing; definitions only.
`ifndef LFU_DEFINES_SVH
`define LFU_DEFINES_SVH

// register word offsets (word index on the avalon address port)
`define LFU_ADDR_TABLE_LO 2'h0
`define LFU_ADDR_TABLE_HI 2'h1
`define LFU_ADDR_STATUS 2'h2

// polarity invert vector bit positions
`define LFU_INV_AUX 0
`define LFU_INV_CLK 1
`define LFU_INV_CE 2
`define LFU_INV_LSR 3

// carry input source select
`define LFU_CIN_FABRIC 2'h0
`define LFU_CIN_OPERAND 2'h1
`define LFU_CIN_ONE 2'h2
`define LFU_CIN_ZERO 2'h3

// special gate select, only meaningful with both halves in five-input mode
`define LFU_SPECIAL_NONE 2'h0
`define LFU_SPECIAL_MUX 2'h1
`define LFU_SPECIAL_XOR 2'h2

// reset values
`define LFU_TABLE_RST 64'h0000_0000_0000_0000
`define LFU_STORE_RST 4'h0
`define LFU_WAIT_RST 1'b1

`endif

// [verilog/lfu_pkg.sv]
// types shared by the logic function unit and its bench.
// assumes lfu_defines.svh for numeric constants.
package lfu_pkg;

  typedef enum logic [3:0] {
    MODE_SPLIT = 4'b0001,
    MODE_RIPPLE = 4'b0010,
    MODE_SYNC_SINGLE_PORT_MEMORY = 4'b0100,
    MODE_SYNC_DUAL_PORT_MEMORY = 4'b1000
  } lut_mode_t;

  typedef enum logic [2:0] {
    HALF_F4 = 3'b001,
    HALF_F5 = 3'b010,
    HALF_MEM = 3'b100
  } half_mode_t;

  typedef struct packed {
    logic global_set_reset_n;
    logic carry_input;
    logic local_set_reset;
    logic ce;
    logic ck;
    logic c0;
    logic [3:0] wd;
    logic [4:0] b;
    logic [4:0] a;
  } pins_t;

  typedef struct packed {
    pins_t pin1;
    pins_t pin2;
    logic ck_prev;
    logic [63:0] table_bits;
    logic [3:0] store;
    logic [4:0] unit_out;
    logic carry_out;
    logic wait_req;
    logic [31:0] rdata;
  } state_t;

endpackage

// [verilog/logic_function_unit.sv]
// logic function unit: 64-bit table in four quarters plus four storage elements.
// assumes fabric pins arrive asynchronous to sys_clk_i and are synchronised here;
// configuration inputs are static straps held steady before reset release.
// Operation
// - twenty inputs, six outputs, meaning set by mode
// - two 5-bit operands, 4-bit write data, controls
// - table: halves of two quarters, quarter k drives k
// - storage from table or write data; bypass outputs
// - dual-port memory: write data feeds table memory
// - one clock, enable, set/reset for all four
// - every control input has an invert option; here only aux, clock, enable and local set/reset have one
// - enable low holds storage; enable may be disabled
// - per element set or clear; global always asynchronous
// - local set/reset sync or async, off by default
// - asynchronous set/reset overrides clocked capture
// - aux control feeds special gates, write enable
// - nine table modes supported
// - ripple mode takes the whole table
// - halves configured independently outside ripple/synchronous memory
// - paired four-input quarters share operand bits 1-3
// - paired outputs go to storage or unit outputs
// - five-input results on quarters zero and three
// - five-input and paired halves may mix
// - six-input function via mux special gate
// - table is readable and writable static memory
// - async 16x2 memory per half, selected separately
// - mux special: aux high selects quarter three
// - carry source: fabric, operand bit, one, zero
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`include "lfu_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module logic_function_unit
  import lfu_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [4:0] operand_upper_i,
  input wire logic [4:0] operand_lower_i,
  input wire logic [3:0] write_data_bus_i,
  input wire logic auxiliary_control_in_i,
  input wire logic cell_clock_i,
  input wire logic clock_enable_i,
  input wire logic local_set_reset_i,
  input wire logic carry_input_i,
  input wire logic global_set_reset_n_i,
  output logic [4:0] unit_out_o,
  output logic carry_output_o,
  input wire lut_mode_t lut_mode_i,
  input wire half_mode_t upper_mode_i,
  input wire half_mode_t lower_mode_i,
  input wire logic [1:0] special_i,
  input wire logic [3:0] invert_i,
  input wire logic aux_used_i,
  input wire logic ce_used_i,
  input wire logic lsr_used_i,
  input wire logic lsr_async_i,
  input wire logic latch_mode_i,
  input wire logic [3:0] set_value_i,
  input wire logic [3:0] store_src_i,
  input wire logic [3:0] bypass_i,
  input wire logic [1:0] carry_sel_i,
  input wire logic [1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);

  state_t q;
  state_t s;

  function automatic logic lut16(input logic [15:0] t, input logic [3:0] idx);
    lut16 = t[idx];
  endfunction

  function automatic logic lut32(input logic [31:0] t, input logic [4:0] idx);
    lut32 = t[idx];
  endfunction

  always_comb begin
    pins_t p;
    logic aux;
    logic clk_lvl;
    logic ce_ok;
    logic lsr_on;
    logic gsr;
    logic clk_edge;
    logic capture;
    logic we_port;
    logic [3:0] f;
    logic [3:0] dsel;
    logic carry;
    logic prop;
    logic gen;
    logic is_ripple;
    logic [63:0] t;
    p = '0;
    aux = 1'b0;
    clk_lvl = 1'b0;
    ce_ok = 1'b0;
    lsr_on = 1'b0;
    gsr = 1'b0;
    clk_edge = 1'b0;
    capture = 1'b0;
    we_port = 1'b0;
    f = 4'h0;
    dsel = 4'h0;
    carry = 1'b0;
    prop = 1'b0;
    gen = 1'b0;
    is_ripple = 1'b0;
    t = q.table_bits;
    s = q;

    // two-stage synchroniser for every fabric pin; stage one feeds only stage two
    s.pin1.a = operand_upper_i;
    s.pin1.b = operand_lower_i;
    s.pin1.wd = write_data_bus_i;
    s.pin1.c0 = auxiliary_control_in_i;
    s.pin1.ck = cell_clock_i;
    s.pin1.ce = clock_enable_i;
    s.pin1.local_set_reset = local_set_reset_i;
    s.pin1.carry_input = carry_input_i;
    s.pin1.global_set_reset_n = global_set_reset_n_i;
    s.pin2 = q.pin1;
    p = q.pin2;

    // configuration straps are read, never stored or altered here
    aux = aux_used_i & (p.c0 ^ invert_i[`LFU_INV_AUX]);
    clk_lvl = p.ck ^ invert_i[`LFU_INV_CLK];
    ce_ok = ~ce_used_i | (p.ce ^ invert_i[`LFU_INV_CE]);
    lsr_on = lsr_used_i & (p.local_set_reset ^ invert_i[`LFU_INV_LSR]);
    gsr = ~p.global_set_reset_n;
    clk_edge = clk_lvl & ~q.ck_prev;
    s.ck_prev = clk_lvl;
    // with aux unused the write port is always enabled
    we_port = ~aux_used_i | aux;
    is_ripple = (lut_mode_i == MODE_RIPPLE);

    // table read side, quarter k lives in bits 16k+15..16k
    case (lut_mode_i)
      MODE_RIPPLE: begin
        // whole table is the ripple chain, nothing else shares it
        case (carry_sel_i)
          `LFU_CIN_FABRIC: carry = p.carry_input;
          `LFU_CIN_OPERAND: carry = p.b[4];
          `LFU_CIN_ONE: carry = 1'b1;
          default: carry = 1'b0;
        endcase
        for (int k = 0; k < 4; k++) begin
          // low 8 entries propagate, high 8 generate, indexed by mode bit a4
          prop = lut16(t[16*k +: 16], {1'b0, p.a[4], p.a[k], p.b[k]});
          gen = lut16(t[16*k +: 16], {1'b1, p.a[4], p.a[k], p.b[k]});
          f[k] = prop ^ carry;
          carry = prop ? carry : gen;
        end
      end
      MODE_SYNC_SINGLE_PORT_MEMORY: begin
        for (int k = 0; k < 4; k++) begin
          f[k] = lut16(t[16*k +: 16], p.a[3:0]);
        end
      end
      MODE_SYNC_DUAL_PORT_MEMORY: begin
        // lower half answers the write address, upper half the read address
        f[0] = lut16(t[15:0], p.a[3:0]);
        f[1] = lut16(t[31:16], p.a[3:0]);
        f[2] = lut16(t[47:32], p.b[3:0]);
        f[3] = lut16(t[63:48], p.b[3:0]);
      end
      default: begin
        // each half follows its own mode
        case (upper_mode_i)
          HALF_F4: begin
            f[2] = lut16(t[47:32], p.a[3:0]);
            f[3] = lut16(t[63:48], {p.a[3:1], p.a[4]});
          end
          HALF_F5: begin
            f[3] = lut32(t[63:32], p.a);
          end
          HALF_MEM: begin
            f[2] = lut16(t[47:32], p.a[3:0]);
            f[3] = lut16(t[63:48], p.a[3:0]);
          end
          default: begin
            f[3:2] = 2'b00;
          end
        endcase
        case (lower_mode_i)
          HALF_F4: begin
            f[0] = lut16(t[15:0], p.b[3:0]);
            f[1] = lut16(t[31:16], {p.b[3:1], p.b[4]});
          end
          HALF_F5: begin
            f[0] = lut32(t[31:0], p.b);
          end
          HALF_MEM: begin
            f[0] = lut16(t[15:0], p.b[3:0]);
            f[1] = lut16(t[31:16], p.b[3:0]);
          end
          default: begin
            f[1:0] = 2'b00;
          end
        endcase
        if (upper_mode_i == HALF_F5 && lower_mode_i == HALF_F5 &&
            special_i != `LFU_SPECIAL_NONE) begin
          // same operands on both buses plus aux makes any six-input function
          if (special_i == `LFU_SPECIAL_MUX) begin
            f[1] = aux ? f[3] : f[0];
          end else begin
            f[1] = f[3] ^ f[0] ^ aux;
          end
          f[2] = ~(f[3] & f[0] & aux);
        end
      end
    endcase

    // bus writes land first so a same-cycle hardware write wins the bit
    if (avs_write_i && !q.wait_req) begin
      for (int n = 0; n < 4; n++) begin
        if (avs_byteenable_i[n]) begin
          if (avs_address_i == `LFU_ADDR_TABLE_LO) begin
            s.table_bits[8*n +: 8] = avs_writedata_i[8*n +: 8];
          end else if (avs_address_i == `LFU_ADDR_TABLE_HI) begin
            s.table_bits[32 + 8*n +: 8] = avs_writedata_i[8*n +: 8];
          end
        end
      end
    end

    // table write side
    case (lut_mode_i)
      MODE_SPLIT: begin
        // asynchronous memory writes follow the write-enable level
        if (upper_mode_i == HALF_MEM && p.a[4] && we_port) begin
          s.table_bits[32 + int'(p.a[3:0])] = p.wd[2];
          s.table_bits[48 + int'(p.a[3:0])] = p.wd[3];
        end
        if (lower_mode_i == HALF_MEM && p.b[4] && we_port) begin
          s.table_bits[int'(p.b[3:0])] = p.wd[0];
          s.table_bits[16 + int'(p.b[3:0])] = p.wd[1];
        end
      end
      MODE_SYNC_SINGLE_PORT_MEMORY: begin
        if (clk_edge && p.a[4] && we_port) begin
          for (int k = 0; k < 4; k++) begin
            s.table_bits[16*k + int'(p.a[3:0])] = p.wd[k];
          end
        end
      end
      MODE_SYNC_DUAL_PORT_MEMORY: begin
        // both halves hold the same 16x2 image so the read port sees the writes
        if (clk_edge && p.a[4] && we_port) begin
          s.table_bits[int'(p.a[3:0])] = p.wd[0];
          s.table_bits[16 + int'(p.a[3:0])] = p.wd[1];
          s.table_bits[32 + int'(p.a[3:0])] = p.wd[0];
          s.table_bits[48 + int'(p.a[3:0])] = p.wd[1];
        end
      end
      default: begin
        s.table_bits = s.table_bits;
      end
    endcase

    // storage elements share clock, enable and set/reset
    // latch is transparent while the clock level is active
    capture = ce_ok & (latch_mode_i ? clk_lvl : clk_edge);
    for (int k = 0; k < 4; k++) begin
      // synchronous memory modes take write data into the table, not the storage
      dsel[k] = (store_src_i[k] && lut_mode_i != MODE_SYNC_DUAL_PORT_MEMORY &&
                 lut_mode_i != MODE_SYNC_SINGLE_PORT_MEMORY) ? p.wd[k] : f[k];
      if (gsr || (lsr_on && lsr_async_i)) begin
        s.store[k] = set_value_i[k];
      end else if (capture) begin
        s.store[k] = (lsr_on && !lsr_async_i) ? set_value_i[k] : dsel[k];
      end
    end

    // outputs pick storage or the quarter result directly
    for (int k = 0; k < 4; k++) begin
      s.unit_out[k] = bypass_i[k] ? f[k] : s.store[k];
    end
    s.unit_out[4] = is_ripple & carry;
    s.carry_out = is_ripple & carry;

    // avalon slave: one wait cycle, answer on the second cycle of a request
    s.wait_req = ~((avs_read_i | avs_write_i) & q.wait_req);
    if (avs_read_i && q.wait_req) begin
      case (avs_address_i)
        `LFU_ADDR_TABLE_LO: s.rdata = t[31:0];
        `LFU_ADDR_TABLE_HI: s.rdata = t[63:32];
        `LFU_ADDR_STATUS: s.rdata = {22'h0, q.carry_out, q.unit_out, q.store};
        default: s.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
      q.table_bits <= `LFU_TABLE_RST;
      q.store <= `LFU_STORE_RST;
      q.wait_req <= `LFU_WAIT_RST;
    end else begin
      q <= s;
    end
  end

  assign unit_out_o = q.unit_out;
  assign carry_output_o = q.carry_out;
  assign avs_readdata_o = q.rdata;
  assign avs_waitrequest_o = q.wait_req;

endmodule

`default_nettype wire

// [bench/fabric_model.sv]
// routing fabric side: makes cell clock pulses on request.
// assumes pulse_i is a one-cycle request in the sys_clk_i domain.
`timescale 1ns/1ps
`default_nettype none
module fabric_model (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic pulse_i,
  output logic cell_clock_o
);
  logic [2:0] cnt_q;
  // three cycles high, then at least four low before the next request is taken
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= 3'h0;
      cell_clock_o <= 1'b0;
    end else begin
      if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
      else if (pulse_i) cnt_q <= 3'h6;
      cell_clock_o <= (cnt_q > 3'h3);
    end
  end
endmodule
`default_nettype wire

// [bench/lfu_assertions.sv]
// checker of the logic function unit ports.
// assumes static configuration and the three-edge pin pipeline.
`timescale 1ns/1ps
`default_nettype none
module lfu_checker
  import lfu_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic auxiliary_control_in_i,
  input wire logic clock_enable_i,
  input wire logic local_set_reset_i,
  input wire logic global_set_reset_n_i,
  input wire logic [4:0] unit_out_o,
  input wire logic carry_output_o,
  input wire lut_mode_t lut_mode_i,
  input wire half_mode_t upper_mode_i,
  input wire half_mode_t lower_mode_i,
  input wire logic [1:0] special_i,
  input wire logic [3:0] invert_i,
  input wire logic aux_used_i,
  input wire logic ce_used_i,
  input wire logic lsr_used_i,
  input wire logic lsr_async_i,
  input wire logic [3:0] set_value_i,
  input wire logic [3:0] bypass_i,
  input wire logic [1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [2:0] up_q;
  logic mux_on;
  logic ax;
  // outputs lag reset release by the pipeline, so gate checks on up_q
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  assign mux_on = lut_mode_i == MODE_SPLIT && upper_mode_i == HALF_F5 &&
    lower_mode_i == HALF_F5 && special_i == 2'h1 && bypass_i == 4'hf &&
    !invert_i[0] && up_q == 3'h7;
  assign ax = auxiliary_control_in_i && aux_used_i;
  a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("bus answer late");
  a_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_hole_zero: assert property (avs_read_i && avs_waitrequest_o && avs_address_i == 2'h3
    |=> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
  a_no_carry: assert property (lut_mode_i != MODE_RIPPLE |-> !carry_output_o &&
    !unit_out_o[4]) else $error("carry outside ripple");
  a_mux_pick: assert property (mux_on && $past(ax, 2) == $past(ax, 4) |->
    unit_out_o[1] == ($past(ax, 3) ? unit_out_o[3] : unit_out_o[0]))
    else $error("mux gate wrong");
  a_nand_gate: assert property (mux_on && $past(ax, 2) == $past(ax, 4) |->
    unit_out_o[2] == !(unit_out_o[3] && unit_out_o[0] && $past(ax, 3)))
    else $error("nand gate wrong");
  a_ce_hold: assert property ((!clock_enable_i && global_set_reset_n_i &&
    !local_set_reset_i)[*6] ##0 (ce_used_i && !invert_i[2] && up_q == 3'h7) |->
    $stable(unit_out_o[3:0] & ~bypass_i)) else $error("storage moved");
  a_gsr_value: assert property (!global_set_reset_n_i[*6] |->
    (unit_out_o[3:0] & ~bypass_i) == (set_value_i & ~bypass_i))
    else $error("global set wrong");
  a_lsr_async: assert property ((local_set_reset_i && !invert_i[3])[*6] ##0
    (lsr_used_i && lsr_async_i) |-> (unit_out_o[3:0] & ~bypass_i) ==
    (set_value_i & ~bypass_i)) else $error("local set wrong");
endmodule
bind logic_function_unit lfu_checker u_chk (.sys_clk_i, .resetn_i,
  .auxiliary_control_in_i, .clock_enable_i, .local_set_reset_i,
  .global_set_reset_n_i, .unit_out_o, .carry_output_o, .lut_mode_i, .upper_mode_i,
  .lower_mode_i, .special_i, .invert_i, .aux_used_i, .ce_used_i, .lsr_used_i,
  .lsr_async_i, .set_value_i, .bypass_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_readdata_o, .avs_waitrequest_o);
`default_nettype wire

// [bench/tb.sv]
// self-checking bench of the logic function unit.
// assumes fabric_model for cell clock pulses and lfu_checker bound in.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  import lfu_pkg::*;
  logic clk, rst_n, aux, ce, local_set_reset, carry_input, gsr_n, pulse, ck, rd, wr, wait_o, carry_output, c;
  logic lsr_on, lsr_as, ce_on;
  logic [4:0] a, b, uo, e;
  logic [3:0] wd, sv, bp, ss, inv;
  logic [1:0] adr, csel, spec;
  logic [31:0] wdat, rdat, r;
  logic [63:0] tbl;
  lut_mode_t mode;
  half_mode_t hm;
  int error_cnt, samples_checked;
  logic_function_unit DUT (.sys_clk_i(clk), .resetn_i(rst_n), .operand_upper_i(a),
    .operand_lower_i(b), .write_data_bus_i(wd), .auxiliary_control_in_i(aux),
    .cell_clock_i(ck), .clock_enable_i(ce), .local_set_reset_i(local_set_reset),
    .carry_input_i(carry_input), .global_set_reset_n_i(gsr_n), .unit_out_o(uo),
    .carry_output_o(carry_output), .lut_mode_i(mode), .upper_mode_i(hm), .lower_mode_i(hm),
    .special_i(spec), .invert_i(inv), .aux_used_i(1'b1), .ce_used_i(ce_on),
    .lsr_used_i(lsr_on), .lsr_async_i(lsr_as), .latch_mode_i(1'b0),
    .set_value_i(sv), .store_src_i(ss), .bypass_i(bp), .carry_sel_i(csel),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o));
  fabric_model u_fab (.sys_clk_i(clk), .resetn_i(rst_n), .pulse_i(pulse),
    .cell_clock_o(ck));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [4:0] ripple(input logic [63:0] t, input logic [4:0] x,
      input logic [4:0] y, input logic ci);
    logic p, g;
    logic [4:0] res;
    for (int k = 0; k < 4; k++) begin
      p = t[16 * k + 4 * x[4] + 2 * x[k] + y[k]];
      g = t[16 * k + 8 + 4 * x[4] + 2 * x[k] + y[k]];
      res[k] = p ^ ci;
      ci = p ? ci : g;
    end
    res[4] = ci;
    return res;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [1:0] ad, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= ad;
    wdat <= d;
    do begin
      @(posedge clk);
      i++;
    end while (wait_o !== 1'b0 && i < 50);
    if (i >= 50) error_cnt++;
    r = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic cell_pulse();
    @(posedge clk);
    pulse <= 1'b1;
    @(posedge clk);
    pulse <= 1'b0;
    tick(10);
  endtask
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    {rst_n, aux, local_set_reset, carry_input, pulse, rd, wr, lsr_on, a, b, wd, adr, wdat, inv, csel} = '0;
    {ce, gsr_n, lsr_as, ce_on} = 4'hf;
    sv = 4'ha;
    bp = 4'hf;
    ss = 4'hf;
    spec = 2'h1;
    mode = MODE_SPLIT;
    hm = HALF_F5;
    error_cnt = 0;
    samples_checked = 0;
    void'($urandom(32'h67c6352c));
    tick(20);
    rst_n <= 1'b1;
    tick(8);
    bus(1'b0, 2'h2, 32'h0);
    `CHK(r[3:0], sv)
    tbl = {$urandom, $urandom};
    bus(1'b1, 2'h0, tbl[31:0]);
    bus(1'b1, 2'h1, tbl[63:32]);
    bus(1'b0, 2'h0, 32'h0);
    `CHK(r, tbl[31:0])
    bus(1'b0, 2'h1, 32'h0);
    `CHK(r, tbl[63:32])
    bus(1'b1, 2'h3, 32'hffff_ffff);
    bus(1'b0, 2'h3, 32'h0);
    `CHK(r, 32'h0)
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      a <= 5'($urandom);
      b <= 5'($urandom);
      aux <= 1'($urandom);
      tick(6);
      `CHK(uo[3], tbl[32 + a])
      `CHK(uo[0], tbl[b])
      `CHK(uo[1], aux ? tbl[32 + a] : tbl[b])
      `CHK(uo[2], ~(tbl[32 + a] & tbl[b] & aux))
      `CHK({uo[4], carry_output}, 2'b00)
    end
    @(posedge clk);
    wd <= 4'($urandom);
    cell_pulse();
    bus(1'b0, 2'h2, 32'h0);
    `CHK(r[3:0], wd)
    @(posedge clk);
    ce <= 1'b0;
    wd <= ~wd;
    cell_pulse();
    bus(1'b0, 2'h2, 32'h0);
    `CHK(r[3:0], ~wd)
    @(posedge clk);
    gsr_n <= 1'b0;
    tick(8);
    bus(1'b0, 2'h2, 32'h0);
    `CHK(r[3:0], sv)
    // ripple takes the whole table, so it gets a fresh reset and config
    gsr_n <= 1'b1;
    mode <= MODE_RIPPLE;
    bp <= 4'h7;
    ss <= 4'h0;
    sv <= 4'h5;
    lsr_on <= 1'b1;
    rst_n <= 1'b0;
    tick(20);
    rst_n <= 1'b1;
    tick(8);
    bus(1'b1, 2'h0, tbl[31:0]);
    bus(1'b1, 2'h1, tbl[63:32]);
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      a <= 5'($urandom);
      b <= 5'($urandom);
      carry_input <= 1'($urandom);
      csel <= 2'(i / 8);
      tick(6);
      c = (csel == 2'h0) ? carry_input : (csel == 2'h1) ? b[4] : (csel == 2'h2);
      e = ripple(tbl, a, b, c);
      `CHK({uo[4], uo[2:0]}, {e[4], e[2:0]})
      `CHK(carry_output, e[4])
    end
    @(posedge clk);
    ce <= 1'b1;
    cell_pulse();
    bus(1'b0, 2'h2, 32'h0);
    `CHK(r[3:0], e[3:0])
    @(posedge clk);
    local_set_reset <= 1'b1;
    tick(8);
    bus(1'b0, 2'h2, 32'h0);
    `CHK(r[3:0], sv)
    // paired four-input halves and a synchronous local set/reset
    local_set_reset <= 1'b0;
    lsr_as <= 1'b0;
    mode <= MODE_SPLIT;
    hm <= HALF_F4;
    bp <= 4'hf;
    ss <= 4'hf;
    rst_n <= 1'b0;
    tick(20);
    rst_n <= 1'b1;
    tick(8);
    bus(1'b1, 2'h0, tbl[31:0]);
    bus(1'b1, 2'h1, tbl[63:32]);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      a <= 5'($urandom);
      b <= 5'($urandom);
      tick(6);
      `CHK(uo[0], tbl[b[3:0]])
      `CHK(uo[1], tbl[16 + {b[3:1], b[4]}])
      `CHK(uo[2], tbl[32 + a[3:0]])
      `CHK(uo[3], tbl[48 + {a[3:1], a[4]}])
    end
    @(posedge clk);
    wd <= 4'ha;
    cell_pulse();
    @(posedge clk);
    local_set_reset <= 1'b1;
    tick(8);
    bus(1'b0, 2'h2, 32'h0);
    `CHK(r[3:0], 4'ha)
    cell_pulse();
    bus(1'b0, 2'h2, 32'h0);
    `CHK(r[3:0], sv)
    report_and_stop();
  end
endmodule
`default_nettype wire
